//--- rtl/run_test_pkg.sv
/*
 * constants, types and helpers shared by the boundary run-test engine.
 * assumes a 125 MHz system clock and a slow, gated test clock
 * that reaches the block as an ordinary asynchronous input.
 */
package run_test_pkg;

	// test controller state codes, as driven by the outside tap controller
	localparam logic [3:0] TAP_RESET       = 4'hF;
	localparam logic [3:0] TAP_RUN_IDLE    = 4'hC;
	localparam logic [3:0] TAP_CAPTURE_DR  = 4'h6;
	localparam logic [3:0] TAP_SHIFT_DR    = 4'h2;

	// instruction codes
	localparam logic [7:0] RUN_BOUNDARY_TEST_CODE = 8'h09;
	localparam logic [7:0] CHAIN_SCAN_NORMAL_CODE = 8'h8E;
	localparam logic [7:0] CHAIN_SCAN_TEST_CODE   = 8'h0F;

	// boundary chain layout
	localparam int CTRL_W       = 3;
	localparam int CELL_W       = 36;
	localparam int HALF_W       = 18;
	localparam int BYTE_W       = 9;
	localparam int CHAIN_W      = 44;
	localparam int B_LSB        = 0;
	localparam int A_LSB        = 18;
	localparam int B1A_OE_BIT   = 40;
	localparam int B1B_OE_BIT   = 41;
	localparam int B2A_OE_BIT   = 42;
	localparam int B2B_OE_BIT   = 43;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// feedback taps: x^36+x^25+1 and x^18+x^11+1, both maximal length
	localparam int TAP36_HI = 35;
	localparam int TAP36_LO = 24;
	localparam int TAP18_HI = 17;
	localparam int TAP18_LO = 10;

	// register map, byte addresses
	localparam logic [7:0] STATUS_OFS  = 8'h00;
	localparam logic [7:0] CHAIN_LO_OFS = 8'h04;
	localparam logic [7:0] CHAIN_HI_OFS = 8'h08;
	localparam logic [7:0] SEED_LO_OFS = 8'h0C;
	localparam logic [7:0] SEED_HI_OFS = 8'h10;
	localparam logic [7:0] LOAD_OFS    = 8'h14;
	localparam logic [31:0] SEED_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		OP_TOGGLE    = 3'h0,
		OP_PATTERN   = 3'h1,
		OP_SIGNATURE = 3'h3,
		OP_CMP_PAT   = 3'h2,
		OP_CMP_CNT   = 3'h6
	} op_t;

	typedef struct packed {
		logic        tck;
		logic        tdi;
		logic [3:0]  state;
		logic [7:0]  instr;
		logic [17:0] a_pin;
		logic [17:0] b_pin;
	} tap_in_t;

	function automatic logic [35:0] step36(input logic [35:0] r);
		step36 = {r[34:0], r[TAP36_HI] ^ r[TAP36_LO]};
	endfunction

	function automatic logic [17:0] step18(input logic [17:0] r);
		step18 = {r[16:0], r[TAP18_HI] ^ r[TAP18_LO]};
	endfunction

	function automatic op_t decode_op(input logic [2:0] c);
		unique case (c[1:0])
			2'b00: decode_op = OP_TOGGLE;
			2'b01: decode_op = OP_PATTERN;
			2'b10: decode_op = OP_SIGNATURE;
			default: decode_op = c[2] ? OP_CMP_CNT : OP_CMP_PAT;
		endcase
	endfunction

endpackage

//--- rtl/boundary_run_test_engine.sv
/*
 * boundary-control chain and run-test operations on the boundary cells,
 * with an apb slave for seeding and reading the chain.
 * assumes the tap state, instruction and test clock arrive from an
 * outside tap controller; all of them are resynchronised here.
 */
`timescale 1ns/1ps

// What this block does
// - control-chain scan puts the chain between tdi and tdo; capture keeps it
// - operation comes from chain bits 2..0, runs only in run-test/idle
// - codes x00 toggle, x01 36-bit pattern, x10 36-bit signature
// - 011 18-bit signature plus pattern, 111 18-bit signature plus count
// - control cells stay out of algorithms; enable cells still gate drive
// - run only with one direction per byte, same for both; else bypass
// - toggle mode samples input pins into input cells each tck rise
// - toggle mode inverts output cells on rise, drives them on fall
// - 36-bit pattern steps on rise, latched and driven on fall
// - an all-zero seed leaves the generators stuck at zero
// - 36-bit signature shifts all cells and folds input pins into input cells on rise
// - during 36-bit signature output hold latches stay unchanged
// - both combined modes fold input pins into 18-bit input signature
// - combined pattern mode steps output cells 18-bit, driven on fall
// - combined count mode counts output cells up, driven on fall
// - chain arrangement follows the common direction: a out or b out
// - operation runs while run-test instruction current and idle state
// - chain scan codes 10001110 normal and 00001111 test
// - enable cell at 1 makes its pins outputs, 0 leaves them inputs
module boundary_run_test_engine (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        clk_en_i,
	input  wire logic        tck_i,
	input  wire logic        tdi_i,
	input  wire logic [3:0]  tap_state_i,
	input  wire logic [7:0]  instr_i,
	input  wire logic [17:0] a_pin_i,
	input  wire logic [17:0] b_pin_i,
	output logic      [17:0] a_pin_o,
	output logic      [17:0] a_pin_oe_o,
	output logic      [17:0] b_pin_o,
	output logic      [17:0] b_pin_oe_o,
	output logic             tdo_o,
	output logic             tdo_oe_o,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	run_test_pkg::tap_in_t sync1_q;
	run_test_pkg::tap_in_t sync2_q;
	logic                  tck_prev_q;
	logic [2:0]            ctrl_chain_q;
	logic                  bypass_q;
	logic [43:0]           chain_q;
	logic [35:0]           shadow_q;
	logic [31:0]           seed_lo_q;
	logic [11:0]           seed_hi_q;
	logic                  rise;
	logic                  fall;
	logic                  is_run_boundary_test_instr;
	logic                  is_scan;
	logic                  dir_ok;
	logic                  a_out;
	logic                  run_ok;
	logic                  out_latch;
	run_test_pkg::op_t     op;
	logic [17:0]           out_cells;
	logic [17:0]           in_cells;
	logic [17:0]           in_pins;
	logic [35:0]           cat36;
	logic [35:0]           next36;
	logic [17:0]           next_out;
	logic [17:0]           next_in;
	logic                  apb_setup;
	logic                  load_seed;

	// tck sampled like any pin; data lines share its delay
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			tck_prev_q <= 1'b0;
		end else if (clk_en_i) begin
			sync1_q    <= {tck_i, tdi_i, tap_state_i, instr_i, a_pin_i, b_pin_i};
			sync2_q    <= sync1_q;
			tck_prev_q <= sync2_q.tck;
		end
	end

	assign rise    = clk_en_i & sync2_q.tck & ~tck_prev_q;
	assign fall    = clk_en_i & ~sync2_q.tck & tck_prev_q;
	assign is_run_boundary_test_instr = sync2_q.instr == run_test_pkg::RUN_BOUNDARY_TEST_CODE;
	assign is_scan = (sync2_q.instr == run_test_pkg::CHAIN_SCAN_NORMAL_CODE)
		| (sync2_q.instr == run_test_pkg::CHAIN_SCAN_TEST_CODE);

	// direction check over the enable cells, which no algorithm touches
	assign dir_ok = (chain_q[run_test_pkg::B1A_OE_BIT]
		!= chain_q[run_test_pkg::B1B_OE_BIT])
		& (chain_q[run_test_pkg::B2A_OE_BIT]
		!= chain_q[run_test_pkg::B2B_OE_BIT])
		& (chain_q[run_test_pkg::B1A_OE_BIT]
		== chain_q[run_test_pkg::B2A_OE_BIT]);
	assign a_out  = chain_q[run_test_pkg::B1A_OE_BIT];
	assign run_ok = is_run_boundary_test_instr & dir_ok
		& (sync2_q.state == run_test_pkg::TAP_RUN_IDLE);
	assign op     = run_test_pkg::decode_op(ctrl_chain_q);

	// arrange cells as output half above input half for either direction
	assign out_cells = a_out ? chain_q[35:18] : chain_q[17:0];
	assign in_cells  = a_out ? chain_q[17:0] : chain_q[35:18];
	assign in_pins   = a_out ? sync2_q.b_pin : sync2_q.a_pin;
	assign cat36     = {out_cells, in_cells};

	always_comb begin
		next36   = cat36;
		next_out = out_cells;
		next_in  = in_cells;
		unique case (op)
			run_test_pkg::OP_TOGGLE: begin
				next_in  = in_pins;
				next_out = ~out_cells;
			end
			run_test_pkg::OP_PATTERN: begin
				next36   = run_test_pkg::step36(cat36);
				next_out = next36[35:18];
				next_in  = next36[17:0];
			end
			run_test_pkg::OP_SIGNATURE: begin
				next36   = run_test_pkg::step36(cat36) ^ {18'h0_0000, in_pins};
				next_out = next36[35:18];
				next_in  = next36[17:0];
			end
			run_test_pkg::OP_CMP_PAT: begin
				next_in  = run_test_pkg::step18(in_cells) ^ in_pins;
				next_out = run_test_pkg::step18(out_cells);
			end
			run_test_pkg::OP_CMP_CNT: begin
				next_in  = run_test_pkg::step18(in_cells) ^ in_pins;
				next_out = out_cells + 18'h0_0001;
			end
		endcase
	end

	// the 36-bit signature freezes the output hold latches
	assign out_latch = run_ok & (op != run_test_pkg::OP_SIGNATURE);

	// control chain: shifts, clears in tap reset; capture leaves it alone
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_chain_q <= run_test_pkg::CTRL_RESET;
		end else if (rise) begin
			if (sync2_q.state == run_test_pkg::TAP_RESET) begin
				ctrl_chain_q <= run_test_pkg::CTRL_RESET;
			end else if (is_scan
				&& sync2_q.state == run_test_pkg::TAP_SHIFT_DR) begin
				ctrl_chain_q <= {sync2_q.tdi, ctrl_chain_q[2:1]};
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bypass_q <= 1'b0;
		end else if (rise) begin
			if (sync2_q.state == run_test_pkg::TAP_CAPTURE_DR) begin
				bypass_q <= 1'b0;
			end else if (sync2_q.state == run_test_pkg::TAP_SHIFT_DR) begin
				bypass_q <= sync2_q.tdi;
			end
		end
	end

	// tdo moves on the falling test-clock edge
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (fall) begin
			tdo_oe_o <= sync2_q.state == run_test_pkg::TAP_SHIFT_DR;
			tdo_o    <= is_scan ? ctrl_chain_q[0] : bypass_q;
		end
	end

	// boundary cells; control cells 43..36 only change by seed load
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chain_q <= '0;
		end else if (clk_en_i) begin
			if (load_seed) begin
				chain_q <= {seed_hi_q, seed_lo_q};
			end else if (rise && run_ok) begin
				chain_q[35:18] <= a_out ? next_out : next_in;
				chain_q[17:0]  <= a_out ? next_in : next_out;
			end
		end
	end

	// hold latches: output half copied on the fall, input half left
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shadow_q <= '0;
		end else if (clk_en_i) begin
			if (load_seed) begin
				shadow_q <= seed_lo_q[31:0] == 32'h0 && seed_hi_q[3:0] == 4'h0
					? 36'h0_0000_0000 : {seed_hi_q[3:0], seed_lo_q};
			end else if (fall && out_latch) begin
				if (a_out) begin
					shadow_q[35:18] <= chain_q[35:18];
				end else begin
					shadow_q[17:0] <= chain_q[17:0];
				end
			end
		end
	end

	// pins: test mode only while the run-test instruction is current and directions valid, else released
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_pin_o    <= '0;
			b_pin_o    <= '0;
			a_pin_oe_o <= '0;
			b_pin_oe_o <= '0;
		end else if (clk_en_i) begin
			a_pin_o    <= shadow_q[35:18];
			b_pin_o    <= shadow_q[17:0];
			a_pin_oe_o <= {{9{is_run_boundary_test_instr & dir_ok & chain_q[run_test_pkg::B2A_OE_BIT]}},
				{9{is_run_boundary_test_instr & dir_ok & chain_q[run_test_pkg::B1A_OE_BIT]}}};
			b_pin_oe_o <= {{9{is_run_boundary_test_instr & dir_ok & chain_q[run_test_pkg::B2B_OE_BIT]}},
				{9{is_run_boundary_test_instr & dir_ok & chain_q[run_test_pkg::B1B_OE_BIT]}}};
		end
	end

	// apb slave, one wait-free access phase
	assign apb_setup = psel & ~penable & ~pready;
	assign load_seed = psel & penable & pready & pwrite
		& (paddr == run_test_pkg::LOAD_OFS) & pwdata[0];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (clk_en_i) begin
			pready  <= apb_setup;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (apb_setup) begin
				unique case (paddr)
					run_test_pkg::STATUS_OFS:
						prdata <= {23'h0, op, ctrl_chain_q, dir_ok, is_run_boundary_test_instr, run_ok};
					run_test_pkg::CHAIN_LO_OFS: prdata <= chain_q[31:0];
					run_test_pkg::CHAIN_HI_OFS: prdata <= {20'h0_0000, chain_q[43:32]};
					run_test_pkg::SEED_LO_OFS:  prdata <= seed_lo_q;
					run_test_pkg::SEED_HI_OFS:  prdata <= {20'h0_0000, seed_hi_q};
					run_test_pkg::LOAD_OFS:     prdata <= '0;
					default:                    pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seed_lo_q <= run_test_pkg::SEED_RESET;
			seed_hi_q <= '0;
		end else if (clk_en_i && psel && penable && pready && pwrite) begin
			if (paddr == run_test_pkg::SEED_LO_OFS) begin
				seed_lo_q <= pwdata;
			end
			if (paddr == run_test_pkg::SEED_HI_OFS) begin
				seed_hi_q <= pwdata[11:0];
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	ctrl_capture_a: assert property (
		rise && sync2_q.state == run_test_pkg::TAP_CAPTURE_DR
		|=> $stable(ctrl_chain_q)) else $error("control chain changed at capture");

	idle_hold_a: assert property (
		rise && !run_ok && !load_seed |=> $stable(chain_q[35:0]))
		else $error("cells moved outside run-test idle");

	toggle_invert_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_TOGGLE && !load_seed
		|=> out_cells == ~$past(out_cells))
		else $error("output cells not inverted");

	toggle_sample_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_TOGGLE && !load_seed
		|=> in_cells == $past(in_pins)) else $error("input pins not sampled");

	zero_stuck_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_PATTERN && cat36 == '0
		&& !load_seed |=> cat36 == '0) else $error("zero seed escaped");

	sig_hold_a: assert property (
		run_ok && op == run_test_pkg::OP_SIGNATURE && !load_seed
		|=> $stable(shadow_q)) else $error("hold latches moved in signature");

	count_up_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_CMP_CNT && !load_seed
		|=> out_cells == $past(out_cells) + 18'h0_0001)
		else $error("count did not advance by one");

	bad_dir_a: assert property (
		clk_en_i && !dir_ok |=> a_pin_oe_o == '0 && b_pin_oe_o == '0)
		else $error("pins driven with bad direction");

	pattern_step_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_PATTERN && !load_seed
		|=> cat36 == run_test_pkg::step36($past(cat36)))
		else $error("pattern did not step");

	sig_fold_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_SIGNATURE && !load_seed
		|=> cat36 == (run_test_pkg::step36($past(cat36))
		^ {18'h0_0000, $past(in_pins)}))
		else $error("signature did not fold pins");

	cmp_fold_a: assert property (
		rise && run_ok && !load_seed && (op == run_test_pkg::OP_CMP_PAT
		|| op == run_test_pkg::OP_CMP_CNT)
		|=> in_cells == (run_test_pkg::step18($past(in_cells))
		^ $past(in_pins))) else $error("18-bit signature wrong");

	cmp_pattern_a: assert property (
		rise && run_ok && op == run_test_pkg::OP_CMP_PAT && !load_seed
		|=> out_cells == run_test_pkg::step18($past(out_cells)))
		else $error("18-bit pattern did not step");

	latch_copy_a: assert property (
		fall && out_latch && !load_seed
		|=> (a_out ? shadow_q[35:18] : shadow_q[17:0]) == $past(out_cells))
		else $error("hold latches not updated on fall");

	toggle_run_c: cover property (rise && run_ok && op == run_test_pkg::OP_TOGGLE);
	pattern_run_c: cover property (rise && run_ok && op == run_test_pkg::OP_PATTERN);
	count_run_c: cover property (rise && run_ok && op == run_test_pkg::OP_CMP_CNT);
	sig_run_c: cover property (rise && run_ok && op == run_test_pkg::OP_SIGNATURE);
	scan_shift_c: cover property (rise && is_scan
		&& sync2_q.state == run_test_pkg::TAP_SHIFT_DR);

endmodule // boundary_run_test_engine

//--- bench/tap_model.sv
/*
 * model of the outside tap controller: makes tck in frames only and
 * drives state, instruction and tdi. assumes the bench calls frame()
 * and that nothing else drives these lines.
 */
`timescale 1ns/1ps
module tap_model (
	output logic       tck_o,
	output logic       tdi_o,
	output logic [3:0] state_o,
	output logic [7:0] instr_o
);
	initial begin
		tck_o = 1'b0;
		tdi_o = 1'b0;
		state_o = 4'hC;
		instr_o = 8'h00;
	end

	// tck stands still between frames; 160 ns period inside one
	task automatic frame(input int n, input logic [3:0] s,
		input logic [7:0] i, input logic [2:0] d);
		for (int k = 0; k < n; k++) begin
			state_o = s;
			instr_o = i;
			tdi_o = d[k % 3];
			#80 tck_o = 1'b1;
			#80 tck_o = 1'b0;
		end
		// released line must not show a stale bit
		tdi_o = ~tdi_o;
		#200;
	endtask
endmodule // tap_model

//--- bench/boundary_run_test_engine_test.sv
/*
 * self-checking bench for the boundary run-test engine.
 * assumes the tap model drives tck and the apb slave answers with pready.
 */
`timescale 1ns/1ps
module test_boundary_run_test_engine;
	logic        ref_clk_i = 1'b0;
	logic        resetn_i  = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [17:0] a_pin_i   = 18'h0;
	logic [17:0] b_pin_i   = 18'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, se, tck, tdi, tdo, tdo_oe;
	logic [17:0] a_pin_o, b_pin_o, a_oe, b_oe;
	logic [3:0]  st;
	logic [7:0]  ins;
	int          err_total  = 0;
	int          num_checks = 0;
	logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};

	always #4 ref_clk_i = ~ref_clk_i;

	tap_model tap_model_inst (.tck_o(tck), .tdi_o(tdi), .state_o(st),
		.instr_o(ins));

	boundary_run_test_engine boundary_run_test_engine_inst (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
		.tck_i(tck), .tdi_i(tdi), .tap_state_i(st), .instr_i(ins),
		.a_pin_i(a_pin_i), .b_pin_i(b_pin_i), .a_pin_o(a_pin_o),
		.a_pin_oe_o(a_oe), .b_pin_o(b_pin_o), .b_pin_oe_o(b_oe),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e,
		input logic [63:0] s);
		num_checks++;
		if (e !== s) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic load(input logic [43:0] v);
		apb(1'b1, run_test_pkg::SEED_LO_OFS, v[31:0]);
		apb(1'b1, run_test_pkg::SEED_HI_OFS, {20'h0, v[43:32]});
		apb(1'b1, run_test_pkg::LOAD_OFS, 32'h1);
	endtask

	task automatic rd_cells(output logic [43:0] v);
		apb(1'b0, run_test_pkg::CHAIN_LO_OFS, 32'h0);
		v[31:0] = rd;
		apb(1'b0, run_test_pkg::CHAIN_HI_OFS, 32'h0);
		v[43:32] = rd[11:0];
	endtask

	// shift the code in lsb first, then a capture that must leave it
	task automatic setop(input logic [2:0] c);
		tap_model_inst.frame(3, run_test_pkg::TAP_SHIFT_DR,
			run_test_pkg::CHAIN_SCAN_NORMAL_CODE, c);
		// after three shifts bit 0 holds the first bit sent
		chk("tdo after shift", {1'b1, c[0]}, {tdo_oe, tdo});
		tap_model_inst.frame(1, run_test_pkg::TAP_CAPTURE_DR,
			run_test_pkg::CHAIN_SCAN_TEST_CODE, 3'h0);
		chk("tdo oe capture", 1'b0, tdo_oe);
		apb(1'b0, run_test_pkg::STATUS_OFS, 32'h0);
		chk("ctrl chain", c, rd[5:3]);
	endtask

	// cells in {output half, input half} order
	function automatic logic [35:0] step(input logic [2:0] c,
		input logic [35:0] r, input logic [17:0] p, input int n);
		for (int k = 0; k < n; k++)
			case (c[1:0])
				2'b00: r = {~r[35:18], p};
				2'b01: r = {r[34:0], r[35] ^ r[24]};
				2'b10: r = {r[34:0], r[35] ^ r[24]} ^ {18'h0, p};
				default: r = {c[2] ? r[35:18] + 18'h1 :
					{r[34:18], r[35] ^ r[28]},
					{r[16:0], r[17] ^ r[10]} ^ p};
			endcase
		return r;
	endfunction

	initial begin
		// about ten times the expected run length
		#200_000;
		err_total++;
		give_verdict();
	end

	initial begin
		logic [43:0] seed, got;
		logic [35:0] r;
		logic [17:0] p;
		logic [2:0]  c, opx;
		logic        aout;
		void'($urandom(32'h1526));
		repeat (5) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		apb(1'b0, run_test_pkg::STATUS_OFS, 32'h0);
		chk("status reset", 32'h0, rd);
		apb(1'b0, run_test_pkg::SEED_LO_OFS, 32'h0);
		chk("seed reset", run_test_pkg::SEED_RESET, rd);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk("unmapped err", 1'b1, se);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped data", 32'h0, rd);
		for (int k = 0; k < 8; k++) begin
			c = codes[k];
			aout = (k % 2) == 0;
			// second pass uses the all-zero seed
			seed = {aout ? 4'h5 : 4'hA, 4'($urandom),
				k == 1 ? 36'h0 : {$urandom, 4'($urandom)}};
			p = 18'($urandom);
			setop(c);
			a_pin_i <= aout ? 18'($urandom) : p;
			b_pin_i <= aout ? p : 18'($urandom);
			load(seed);
			tap_model_inst.frame(5, run_test_pkg::TAP_RUN_IDLE,
				run_test_pkg::RUN_BOUNDARY_TEST_CODE, 3'h0);
			apb(1'b0, run_test_pkg::STATUS_OFS, 32'h0);
			opx = c[1:0] == 2'b00 ? 3'h0 : c[1:0] == 2'b01 ? 3'h1 :
				c[1:0] == 2'b10 ? 3'h3 : {c[2], 2'b10};
			chk("status op", {opx, c, 3'h7}, rd[8:0]);
			r = aout ? seed[35:0] : {seed[17:0], seed[35:18]};
			r = step(c, r, p, 5);
			rd_cells(got);
			chk("cells", {seed[43:36], aout ? r : {r[17:0], r[35:18]}},
				got);
			if (c[1:0] == 2'b10)
				r[35:18] = aout ? seed[35:18] : seed[17:0];
			chk("out pins", r[35:18], aout ? a_pin_o : b_pin_o);
			chk("oe", {aout ? 18'h3FFFF : 18'h0, aout ? 18'h0 : 18'h3FFFF},
				{a_oe, b_oe});
		end
		// byte 1 with both directions enabled: no operation at all
		seed = 44'h301_2345_6789;
		load(seed);
		tap_model_inst.frame(3, run_test_pkg::TAP_RUN_IDLE,
			run_test_pkg::RUN_BOUNDARY_TEST_CODE, 3'h0);
		rd_cells(got);
		chk("bad dir cells", seed, got);
		chk("bad dir oe", 36'h0, {a_oe, b_oe});
		apb(1'b0, run_test_pkg::STATUS_OFS, 32'h0);
		chk("bad dir flag", 1'b0, rd[2]);
		tap_model_inst.frame(1, run_test_pkg::TAP_RESET, 8'h00, 3'h0);
		apb(1'b0, run_test_pkg::STATUS_OFS, 32'h0);
		chk("ctrl after tap reset", 3'h0, rd[5:3]);
		give_verdict();
	end
endmodule // test_boundary_run_test_engine
